// ---- blpwm_top.sv ----
// breathing / blinking led pwm with axi4-lite register slave
//
// Function
// - period counts zero to terminal FFh, FEh or FCh by width
// - period end is the wrap from terminal value to zero; commits happen there
// - registers accept 32, 16 or 8 bit writes, byte lanes independent
// - configuration register writes act immediately
// - limits go via holding copy, committed at every period end
// - in blink mode a single floor byte write changes duty next period
// - hold, step and interval holding copies commit at period end if commit set
// - with commit clear, hold, step and interval holding copies retained and not copied
// - config bit 16 selects asymmetric four-segment or symmetric eight-segment ramps
// - writing one to config bit 7 restores defaults; self clearing
// - config bit 6 commit set by writing one, zero ignored, readable
// - hardware clears commit in the same period end that copies
// - config bits 5:4 pick 8, 7 or 6 bit width; 3 reserved
// - breathing hold and ramp timing count in pwm period ticks
// - offsets: config 00h, limits 04h, hold 08h, step 0Ch, interval 10h, output delay 14h
// - symmetric segment is duty bits 7:5, nibble 4n+3 to 4n
// - asymmetric segment bit 2 is falling, bits 1:0 are duty bits 7:6
// - control 3 on, 2 blink, 1 breathe, 0 off with counters cleared
// - breathing holds at ceiling then falls, holds at floor then rises
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps

module blpwm_top
	import blpwm_pkg::*;
(
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// slow clock pin
	input  wire logic        SLOW_CLK_PIN,
	// axi4-lite write address and data
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output      logic        AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output      logic        WREADY,
	// axi4-lite write response
	output      logic [1:0]  BRESP,
	output      logic        BVALID,
	input  wire logic        BREADY,
	// axi4-lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output      logic        ARREADY,
	output      logic [31:0] RDATA,
	output      logic [1:0]  RRESP,
	output      logic        RVALID,
	input  wire logic        RREADY,
	// led
	output      logic        LED_OUT
);
	import blpwm_pkg::*;

	// ****************************************
	// register state
	// ****************************************
	logic [31:0]   config_reg;
	blpwm_limits_t limits_reg, limits_hold_reg;
	blpwm_hold_t   hold_reg, hold_hold_reg;
	logic [31:0]   step_reg, step_hold_reg;
	logic [31:0]   interval_reg, interval_hold_reg;
	logic [7:0]    out_delay_reg;
	logic [7:0]    pwm_cnt_reg;
	logic [7:0]    duty_reg;
	logic          led_reg;

	logic [7:0]  aw_addr_reg;
	logic        aw_have_reg, w_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r & mask;
	endfunction : merge

	// ****************************************
	// axi4-lite write channel
	// ****************************************
	logic wr_fire;
	assign AWREADY = !aw_have_reg && !BVALID;
	assign WREADY  = !w_have_reg && !BVALID;
	assign wr_fire = aw_have_reg && w_have_reg;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
			BVALID      <= 1'b0;
			BRESP       <= RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_have_reg <= 1'b1;
				w_data_reg <= WDATA;
				w_strb_reg <= WSTRB;
			end
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				BVALID      <= 1'b1;
				BRESP       <= (aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= OFS_OUT_DELAY)
					? RESP_OKAY : RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	logic wr_cfg, wr_lim, wr_hold, wr_step, wr_int, wr_odly;
	assign wr_cfg  = wr_fire && aw_addr_reg == OFS_CONFIG;
	assign wr_lim  = wr_fire && aw_addr_reg == OFS_LIMITS;
	assign wr_hold = wr_fire && aw_addr_reg == OFS_HOLD;
	assign wr_step = wr_fire && aw_addr_reg == OFS_STEP;
	assign wr_int  = wr_fire && aw_addr_reg == OFS_INTERVAL;
	assign wr_odly = wr_fire && aw_addr_reg == OFS_OUT_DELAY;

	// soft reset pulse from config bit 7
	logic soft_rst;
	assign soft_rst = wr_cfg && w_strb_reg[0] && w_data_reg[CFG_SRESET_BIT];

	// ****************************************
	// period timing
	// ****************************************
	logic [1:0] ctrl, width;
	logic [7:0] term;
	logic       period_end, tick_en, slow_s1, slow_s2, slow_s3;
	assign ctrl  = config_reg[CFG_CTRL_LSB +: 2];
	assign width = config_reg[CFG_WIDTH_LSB +: 2];

	always_comb begin
		if (ctrl == CTRL_BLINK) begin
			term = TERM_8;                    // blink is always 8-bit
		end else begin
			case (width)
				WIDTH_7: term = TERM_7;
				WIDTH_6: term = TERM_6;
				default: term = TERM_8;       // reserved code behaves as 8-bit
			endcase
		end
	end

	// slow clock pin is synchronised, then its rising edge is an enable
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			slow_s1 <= 1'b0;
			slow_s2 <= 1'b0;
			slow_s3 <= 1'b0;
		end else begin
			slow_s1 <= SLOW_CLK_PIN;
			slow_s2 <= slow_s1;
			slow_s3 <= slow_s2;
		end
	end

	// blink prescaler is left out; source selects main clock or slow clock edge
	assign tick_en = (ctrl == CTRL_BLINK && !config_reg[CFG_CLKSRC_BIT])
		? (slow_s2 && !slow_s3) : 1'b1;
	assign period_end = tick_en && (pwm_cnt_reg == term) && ctrl != CTRL_OFF;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			pwm_cnt_reg <= 8'h00;
		end else if (ctrl == CTRL_OFF || config_reg[CFG_SYNC_BIT] || soft_rst) begin
			pwm_cnt_reg <= 8'h00;
		end else if (tick_en) begin
			pwm_cnt_reg <= (pwm_cnt_reg == term) ? 8'h00 : pwm_cnt_reg + 8'h01;
		end
	end

	// ****************************************
	// configuration register
	// ****************************************
	logic commit_clr;
	assign commit_clr = period_end && config_reg[CFG_COMMIT_BIT];

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			config_reg <= {16'h0000, SCALE_RESET, 8'h00};
		end else if (soft_rst) begin
			config_reg <= {16'h0000, SCALE_RESET, 8'h00};
		end else begin
			logic [31:0] n;
			n = config_reg;
			if (wr_cfg) begin
				n = merge(config_reg, w_data_reg, w_strb_reg, CFG_RW_MASK);
				n[CFG_COMMIT_BIT] = config_reg[CFG_COMMIT_BIT];
			end
			if (commit_clr) begin
				n[CFG_COMMIT_BIT] = 1'b0;
			end
			// a set that meets the hardware clear wins
			if (wr_cfg && w_strb_reg[0] && w_data_reg[CFG_COMMIT_BIT]) begin
				n[CFG_COMMIT_BIT] = 1'b1;
			end
			config_reg <= n;
		end
	end

	// ****************************************
	// holding and operating registers
	// ****************************************
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			limits_hold_reg <= '0;
			limits_reg      <= '0;
		end else if (soft_rst) begin
			limits_hold_reg <= '0;
			limits_reg      <= '0;
		end else begin
			if (wr_lim) begin
				limits_hold_reg <= 16'(merge({16'h0000, limits_hold_reg}, w_data_reg,
					w_strb_reg, LIMITS_MASK));
			end
			if (period_end) begin
				limits_reg <= limits_hold_reg;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			hold_hold_reg     <= '0;
			step_hold_reg     <= 32'h0000_0000;
			interval_hold_reg <= 32'h0000_0000;
			hold_reg          <= '0;
			step_reg          <= 32'h0000_0000;
			interval_reg      <= 32'h0000_0000;
			out_delay_reg     <= 8'h00;
		end else if (soft_rst) begin
			hold_hold_reg     <= '0;
			step_hold_reg     <= 32'h0000_0000;
			interval_hold_reg <= 32'h0000_0000;
			hold_reg          <= '0;
			step_reg          <= 32'h0000_0000;
			interval_reg      <= 32'h0000_0000;
			out_delay_reg     <= 8'h00;
		end else begin
			if (wr_hold) begin
				hold_hold_reg <= 24'(merge({8'h00, hold_hold_reg}, w_data_reg, w_strb_reg,
					DELAY_MASK));
			end
			if (wr_step) begin
				step_hold_reg <= merge(step_hold_reg, w_data_reg, w_strb_reg, 32'hFFFF_FFFF);
			end
			if (wr_int) begin
				interval_hold_reg <= merge(interval_hold_reg, w_data_reg, w_strb_reg,
					32'hFFFF_FFFF);
			end
			if (wr_odly) begin
				out_delay_reg <= 8'(merge({24'h0, out_delay_reg}, w_data_reg, w_strb_reg,
					OUTDLY_MASK));
			end
			if (commit_clr) begin
				hold_reg     <= hold_hold_reg;
				step_reg     <= step_hold_reg;
				interval_reg <= interval_hold_reg;
			end
		end
	end

	// ****************************************
	// breathing engine
	// ****************************************
	blpwm_phase_t phase_reg;
	logic [11:0]  wait_reg;
	logic [2:0]   seg;
	logic [3:0]   seg_step, seg_int;
	logic [8:0]   up_sum;
	logic [7:0]   dn_dif;

	always_comb begin
		if (config_reg[CFG_ASYM_BIT]) begin
			seg = {phase_reg == BLPWM_FALL, duty_reg[7:6]};
		end else begin
			seg = duty_reg[7:5];
		end
	end
	assign seg_step = step_reg[{seg, 2'b00} +: 4];
	assign seg_int  = interval_reg[{seg, 2'b00} +: 4];
	assign up_sum   = {1'b0, duty_reg} + {5'h00, seg_step};
	assign dn_dif   = (duty_reg > {4'h0, seg_step}) ? duty_reg - {4'h0, seg_step} : 8'h00;

	// one tick per pwm period; ramp slows by the segment interval
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			phase_reg <= BLPWM_HOLD_LOW;
			wait_reg  <= 12'h000;
			duty_reg  <= 8'h00;
		end else if (ctrl != CTRL_BREATHE || soft_rst || config_reg[CFG_SYNC_BIT]) begin
			phase_reg <= BLPWM_HOLD_LOW;
			wait_reg  <= 12'h000;
			duty_reg  <= (ctrl == CTRL_BREATHE) ? limits_reg.floor : 8'h00;
		end else if (period_end) begin
			if (wait_reg != 12'h000) begin
				wait_reg <= wait_reg - 12'h001;
			end else begin
				case (phase_reg)
					BLPWM_HOLD_LOW: begin
						phase_reg <= BLPWM_RISE;
					end
					BLPWM_RISE: begin
						wait_reg <= {8'h00, seg_int};
						if (up_sum[8] || up_sum[7:0] >= limits_reg.ceiling) begin
							duty_reg  <= limits_reg.ceiling;
							phase_reg <= BLPWM_HOLD_HIGH;
							wait_reg  <= hold_reg.ceiling_hold_ticks;
						end else begin
							duty_reg <= up_sum[7:0];
						end
					end
					BLPWM_HOLD_HIGH: begin
						phase_reg <= BLPWM_FALL;
					end
					BLPWM_FALL: begin
						wait_reg <= {8'h00, seg_int};
						if (dn_dif <= limits_reg.floor) begin
							duty_reg  <= limits_reg.floor;
							phase_reg <= BLPWM_HOLD_LOW;
							wait_reg  <= hold_reg.floor_hold_ticks;
						end else begin
							duty_reg <= dn_dif;
						end
					end
					default: phase_reg <= BLPWM_HOLD_LOW;
				endcase
			end
		end
	end

	// ****************************************
	// led output
	// ****************************************
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			led_reg <= 1'b0;
		end else begin
			case (ctrl)
				CTRL_ON:      led_reg <= 1'b1;
				CTRL_BLINK:   led_reg <= (limits_reg.floor == 8'hFF) ||
					(pwm_cnt_reg < limits_reg.floor);
				CTRL_BREATHE: led_reg <= pwm_cnt_reg < duty_reg;
				default:      led_reg <= 1'b0;
			endcase
		end
	end
	assign LED_OUT = led_reg;

	// ****************************************
	// axi4-lite read channel
	// ****************************************
	assign ARREADY = !RVALID;

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			RVALID <= 1'b0;
			RDATA  <= 32'h0000_0000;
			RRESP  <= RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RRESP  <= RESP_OKAY;
			case (ARADDR)
				OFS_CONFIG:    RDATA <= config_reg;
				OFS_LIMITS:    RDATA <= {16'h0000, limits_reg};
				OFS_HOLD:      RDATA <= {8'h00, hold_reg};
				OFS_STEP:      RDATA <= step_reg;
				OFS_INTERVAL:  RDATA <= interval_reg;
				OFS_OUT_DELAY: RDATA <= {24'h000000, out_delay_reg};
				default: begin
					RDATA <= 32'h0000_0000;
					RRESP <= RESP_SLVERR;
				end
			endcase
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

endmodule : blpwm_top

// ---- blpwm_pkg.sv ----
// package: register map, field positions, reset values and types of the breathing led pwm
package blpwm_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_CONFIG    = 8'h00;
	localparam logic [7:0] OFS_LIMITS    = 8'h04;
	localparam logic [7:0] OFS_HOLD      = 8'h08;
	localparam logic [7:0] OFS_STEP      = 8'h0C;
	localparam logic [7:0] OFS_INTERVAL  = 8'h10;
	localparam logic [7:0] OFS_OUT_DELAY = 8'h14;

	// ****************************************
	// configuration fields
	// ****************************************
	localparam int CFG_CTRL_LSB    = 0;
	localparam int CFG_CLKSRC_BIT  = 2;
	localparam int CFG_SYNC_BIT    = 3;
	localparam int CFG_WIDTH_LSB   = 4;
	localparam int CFG_COMMIT_BIT  = 6;
	localparam int CFG_SRESET_BIT  = 7;
	localparam int CFG_SCALE_LSB   = 8;
	localparam int CFG_ASYM_BIT    = 16;
	localparam logic [31:0] CFG_RW_MASK  = 32'h0001_FF3F;
	localparam logic [7:0]  SCALE_RESET  = 8'h14;
	localparam logic [1:0]  CTRL_OFF     = 2'h0;
	localparam logic [1:0]  CTRL_BREATHE = 2'h1;
	localparam logic [1:0]  CTRL_BLINK   = 2'h2;
	localparam logic [1:0]  CTRL_ON      = 2'h3;
	localparam logic [1:0]  WIDTH_8      = 2'h0;
	localparam logic [1:0]  WIDTH_7      = 2'h1;
	localparam logic [1:0]  WIDTH_6      = 2'h2;
	localparam logic [7:0]  TERM_8       = 8'hFF;
	localparam logic [7:0]  TERM_7       = 8'hFE;
	localparam logic [7:0]  TERM_6       = 8'hFC;
	localparam logic [31:0] LIMITS_MASK  = 32'h0000_FFFF;
	localparam logic [31:0] DELAY_MASK   = 32'h00FF_FFFF;
	localparam logic [31:0] OUTDLY_MASK  = 32'h0000_00FF;

	// ****************************************
	// axi4-lite responses
	// ****************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		BLPWM_HOLD_LOW  = 2'b00,
		BLPWM_RISE      = 2'b01,
		BLPWM_HOLD_HIGH = 2'b11,
		BLPWM_FALL      = 2'b10
	} blpwm_phase_t;

	typedef struct packed {
		logic [7:0] ceiling;
		logic [7:0] floor;
	} blpwm_limits_t;

	typedef struct packed {
		logic [11:0] ceiling_hold_ticks;
		logic [11:0] floor_hold_ticks;
	} blpwm_hold_t;

endpackage : blpwm_pkg

// ---- blpwm_monitor.sv ----
// checker: bus handshake and register read rules of the breathing led pwm
`timescale 1ns/1ps

module blpwm_monitor
	import blpwm_pkg::*;
(
	// clock and reset
	input logic        CLOCK,
	input logic        RST_N,
	// write side
	input logic [7:0]  AWADDR,
	input logic        AWVALID,
	input logic        AWREADY,
	input logic        WVALID,
	input logic        WREADY,
	input logic [1:0]  BRESP,
	input logic        BVALID,
	input logic        BREADY,
	// read side
	input logic [7:0]  ARADDR,
	input logic        ARVALID,
	input logic        ARREADY,
	input logic [31:0] RDATA,
	input logic [1:0]  RRESP,
	input logic        RVALID,
	input logic        RREADY
);
	logic [7:0] rd_addr_reg;
	logic       wr_take;

	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	// remembers which register the pending read answers for
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N)
			rd_addr_reg <= 8'h00;
		else if (ARVALID && ARREADY)
			rd_addr_reg <= ARADDR;
	end
	assign wr_take = AWVALID && AWREADY && WVALID && WREADY;

	bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped early");
	ar_block_a: assert property (RVALID |-> !ARREADY)
		else $error("read address taken while answer pending");
	aw_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write taken while response pending");
	read_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	write_answer_a: assert property (wr_take |=> ##[0:1] BVALID)
		else $error("write response late");
	unmapped_read_a: assert property (ARVALID && ARREADY && ARADDR > OFS_OUT_DELAY
		|=> RRESP == RESP_SLVERR && RDATA == 32'h0)
		else $error("unmapped read not refused");
	mapped_write_a: assert property (wr_take && AWADDR == OFS_LIMITS
		|=> ##[0:1] BVALID && BRESP == RESP_OKAY)
		else $error("mapped write refused");
	cfg_reserved_a: assert property (RVALID && rd_addr_reg == OFS_CONFIG
		|-> RDATA[31:17] == 15'h0 && !RDATA[7])
		else $error("config reserved bits set");
	limits_reserved_a: assert property (RVALID && rd_addr_reg == OFS_LIMITS
		|-> RDATA[31:16] == 16'h0)
		else $error("limits reserved bits set");

	cover property (wr_take);
	cover property (RVALID && rd_addr_reg == OFS_CONFIG);
	cover property (ARVALID && ARREADY && ARADDR > OFS_OUT_DELAY);
endmodule : blpwm_monitor

// ---- blpwm_led_model.sv ----
// partner model: led on the pwm pin, counting lit cycles in a window
`timescale 1ns/1ps

module blpwm_led_model (
	// pin and measuring window
	input  logic clock,
	input  logic led_in,
	input  logic window,
	output int   lit_cycles
);
	// a passive load: it only integrates light, so an unknown level never counts as lit
	always_ff @(posedge clock) begin
		if (!window)
			lit_cycles <= 0;
		else if (led_in === 1'h1)
			lit_cycles <= lit_cycles + 1;
	end
endmodule : blpwm_led_model

// ---- breathing_led_pwm_bench.sv ----
// testbench: register access, commit timing and led duty of the breathing led pwm
`timescale 1ns/1ps

module breathing_led_pwm_bench;
	import blpwm_pkg::*;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [3:0]  strb;
		logic [1:0]  bresp;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} blpwm_row_t;
	logic        CLOCK, RST_N, SLOW_CLK_PIN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, LED_OUT, window;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP, rs;
	logic [11:0] slow_cnt;
	int          err_total, num_checks, lit_cycles;
	blpwm_row_t  rows [7];
	logic [7:0]  mode_cfg [4] = '{8'h06, 8'h06, 8'h03, 8'h00};
	logic [7:0]  mode_flo [4] = '{8'h20, 8'hFF, 8'h80, 8'h80};
	logic [31:0] mode_lit [4] = '{32'h40, 32'h200, 32'h200, 32'h0};

	blpwm_top dut (
		.CLOCK(CLOCK), .RST_N(RST_N), .SLOW_CLK_PIN(SLOW_CLK_PIN),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.LED_OUT(LED_OUT)
	);
	blpwm_led_model led (.clock(CLOCK), .led_in(LED_OUT), .window(window), .lit_cycles(lit_cycles));

	initial begin
		CLOCK = 1'h0;
		forever #4 CLOCK = ~CLOCK;
	end
	// a slow square wave keeps the slow-clock synchroniser exercised
	always @(posedge CLOCK) slow_cnt <= slow_cnt + 12'h001;
	assign SLOW_CLK_PIN = slow_cnt[11];

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic print_verdict();
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= s;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		for (n = 0; n < 64; n++) begin
			@(posedge CLOCK);
			if (AWREADY) AWVALID <= 1'h0;
			if (WREADY) WVALID <= 1'h0;
			if (BVALID) break;
		end
		if (n == 64) begin
			err_total++;
			print_verdict();
		end
		rs = BRESP;
		BREADY <= 1'h0;
		@(posedge CLOCK);
	endtask : wr

	task automatic rck(input logic [7:0] a, input logic [31:0] e);
		int n;
		ARADDR <= a;
		ARVALID <= 1'h1;
		RREADY <= 1'h1;
		for (n = 0; n < 64; n++) begin
			@(posedge CLOCK);
			if (ARREADY) ARVALID <= 1'h0;
			if (RVALID) break;
		end
		if (n == 64) begin
			err_total++;
			print_verdict();
		end
		rd = RDATA;
		rs = RRESP;
		RREADY <= 1'h0;
		@(posedge CLOCK);
		chk(rd, e);
	endtask : rck

	// lets the duty settle, then counts lit cycles over a whole number of periods
	task automatic measure(input int settle, input int span, input logic [31:0] e);
		repeat (settle) @(posedge CLOCK);
		window <= 1'h1;
		repeat (span) @(posedge CLOCK);
		#1;
		chk(32'(lit_cycles), e);
		window <= 1'h0;
		@(posedge CLOCK);
	endtask : measure

	initial begin
		{RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, window} = '0;
		{AWADDR, ARADDR, WDATA, WSTRB, slow_cnt} = '0;
		err_total = 0;
		num_checks = 0;
		rows[0] = '{OFS_CONFIG, 32'hFFFF_FF30, 4'hF, RESP_OKAY, 32'h0001_FF30, RESP_OKAY};
		rows[1] = '{OFS_CONFIG, 32'h0000_0000, 4'h2, RESP_OKAY, 32'h0001_0030, RESP_OKAY};
		rows[2] = '{OFS_LIMITS, 32'h1234_5678, 4'hF, RESP_OKAY, 32'h0, RESP_OKAY};
		rows[3] = '{OFS_HOLD, 32'hFFFF_FFFF, 4'hF, RESP_OKAY, 32'h0, RESP_OKAY};
		rows[4] = '{OFS_STEP, 32'hFFFF_FFFF, 4'hF, RESP_OKAY, 32'h0, RESP_OKAY};
		rows[5] = '{OFS_OUT_DELAY, 32'hAAAA_AAAA, 4'h1, RESP_OKAY, 32'h0000_00AA, RESP_OKAY};
		rows[6] = '{8'h18, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR, 32'h0, RESP_SLVERR};
		repeat (20) @(posedge CLOCK);
		RST_N <= 1'h1;
		@(posedge CLOCK);
		for (int a = 0; a < 24; a += 4)
			rck(8'(a), (a == 0) ? 32'h0000_1400 : 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata, rows[i].strb);
			chk(32'(rs), 32'(rows[i].bresp));
			rck(rows[i].addr, rows[i].rdata);
			chk(32'(rs), 32'(rows[i].rresp));
		end
		// ctrl off means no period end, so commit stays pending until the unit runs
		wr(OFS_CONFIG, 32'h0000_0080, 4'h1);
		rck(OFS_CONFIG, 32'h0000_1400);
		rck(OFS_OUT_DELAY, 32'h0);
		wr(OFS_HOLD, 32'h0012_3456, 4'hF);
		wr(OFS_CONFIG, 32'h0000_1440, 4'h1);
		rck(OFS_CONFIG, 32'h0000_1440);
		wr(OFS_CONFIG, 32'h0000_0003, 4'h1);
		rck(OFS_CONFIG, 32'h0000_1443);
		rck(OFS_HOLD, 32'h0);
		repeat (300) @(posedge CLOCK);
		rck(OFS_CONFIG, 32'h0000_1403);
		rck(OFS_HOLD, 32'h0012_3456);
		wr(OFS_HOLD, 32'h0000_0001, 4'h1);
		wr(OFS_LIMITS, 32'h0000_C040, 4'h3);
		repeat (300) @(posedge CLOCK);
		rck(OFS_HOLD, 32'h0012_3456);
		rck(OFS_LIMITS, 32'h0000_C040);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CONFIG, {24'h0, mode_cfg[m]}, 4'h1);
			wr(OFS_LIMITS, {24'h0, mode_flo[m]}, 4'h1);
			measure(300, 512, mode_lit[m]);
		end
		// breathing: floor and ceiling meet, so the ramp settles on that duty
		wr(OFS_STEP, 32'h0000_000F, 4'hF);
		wr(OFS_HOLD, 32'h0, 4'hF);
		wr(OFS_LIMITS, 32'h0000_4040, 4'h3);
		wr(OFS_CONFIG, 32'h0000_0043, 4'h1);
		repeat (300) @(posedge CLOCK);
		rck(OFS_STEP, 32'h0000_000F);
		// asymmetric rise stays in segment zero below 40h; symmetric would stall at 2Dh
		wr(OFS_CONFIG, 32'h0001_0001, 4'h5);
		measure(1700, 512, 32'h80);
		// 6-bit period never reaches FEh, so a duty of FEh lights every cycle
		wr(OFS_STEP, 32'hFFFF_FFFF, 4'hF);
		wr(OFS_LIMITS, 32'h0000_FEFE, 4'h3);
		wr(OFS_CONFIG, 32'h0000_0061, 4'h1);
		measure(4000, 506, 32'h1FA);
		print_verdict();
	end
endmodule : breathing_led_pwm_bench

bind blpwm_top blpwm_monitor mon (
	.CLOCK(CLOCK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
	.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
	.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
);
